// *** verilog/bta_pkg.sv ***
// bus trace trigger capture: shared constants, enums and register map
// assumes a 20 MHz pclk and 32-bit apb data

package bta_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint CLK_HZ = 20_000_000;
  localparam int TAG_ACC_W = 24;
  localparam int TAG_W = 24;
  localparam int TAG_LO_W = 16;
  localparam int NTH_POST_CYCLES = 4096;
  localparam int PROG_MIN_HZ = 50;
  localparam int PROG_MAX_HZ = 50_000;
  localparam int PROG_SH = 16;
  localparam longint PROG_MUL_L =
    ((64'd1 << (TAG_ACC_W + PROG_SH)) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [31:0] PROG_MUL = 32'(PROG_MUL_L);
  localparam longint ONE_MHZ = 1_000_000;
  localparam logic [23:0] INC_16M =
    24'((16 * ONE_MHZ * (64'd1 << TAG_ACC_W) + CLK_HZ / 2) / CLK_HZ);
  localparam logic [23:0] INC_8M =
    24'((8 * ONE_MHZ * (64'd1 << TAG_ACC_W) + CLK_HZ / 2) / CLK_HZ);
  localparam logic [23:0] INC_4M =
    24'((4 * ONE_MHZ * (64'd1 << TAG_ACC_W) + CLK_HZ / 2) / CLK_HZ);
  localparam logic [23:0] INC_2M =
    24'((2 * ONE_MHZ * (64'd1 << TAG_ACC_W) + CLK_HZ / 2) / CLK_HZ);
  localparam logic [23:0] INC_1M =
    24'((ONE_MHZ * (64'd1 << TAG_ACC_W) + CLK_HZ / 2) / CLK_HZ);

  //////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_NTH = 8'h0c;
  localparam logic [7:0] OFF_PROG_REQ = 8'h10;
  localparam logic [7:0] OFF_PROG_HZ = 8'h14;
  localparam logic [7:0] OFF_TERM_CTRL = 8'h18;
  localparam logic [7:0] OFF_TERM_BASE = 8'h20;
  localparam logic [7:0] OFF_TERM_END = 8'h3c;

  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_STOPEMU_BIT = 4;
  localparam int CTRL_MUX_BIT = 5;
  localparam int CTRL_SRC_LSB = 6;
  localparam int CTRL_ARM_BIT = 16;
  localparam int CTRL_DISARM_BIT = 17;
  localparam int CTRL_STOP_BIT = 18;
  // term control: per term nibble {rng, neg, en}
  localparam int TC_EN = 0;
  localparam int TC_NEG = 1;
  localparam int TC_RNG = 2;

  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0100;
  localparam logic [15:0] NTH_RST = 16'h0001;
  localparam logic [15:0] PROG_REQ_RST = 16'h03e8;

  //////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [3:0] {
    mode_cont_all, mode_cont_evt, mode_cnt_all, mode_cnt_evt,
    mode_any, mode_ab_cd, mode_abc_nd, mode_abcd, mode_nth
  } bta_mode_e;

  typedef enum logic [2:0] {
    src_16m, src_8m, src_4m, src_2m, src_1m, src_ext, src_prog, src_emu
  } bta_src_e;

  typedef enum logic [1:0] {st_idle, st_pre, st_post, st_done} bta_state_e;

endpackage : bta_pkg

// *** verilog/bta_if.sv ***
// bus trace trigger capture: carriers between the top and its leaves
// assumes bta_pkg is compiled first

`timescale 1ns/10ps

interface bta_term_if;
  logic [31:0] word;
  logic [31:0] value;
  logic [31:0] care;
  logic [31:0] lo;
  logic en;
  logic neg;
  logic rng;
  logic hit;
  modport cfg(output word, value, care, lo, en, neg, rng, input hit);
  modport term(input word, value, care, lo, en, neg, rng, output hit);
endinterface : bta_term_if

interface bta_tag_if;
  import bta_pkg::*;
  bta_src_e src;
  logic [15:0] prog_req;
  logic bus_stb;
  logic clr;
  logic [23:0] count;
  logic [15:0] prog_hz;
  modport ctl(output src, prog_req, bus_stb, clr, input count, prog_hz);
  modport gen(input src, prog_req, bus_stb, clr, output count, prog_hz);
endinterface : bta_tag_if

// *** verilog/bta_term.sv ***
// bus trace trigger capture: one event term comparator
// assumes word, compare values and enables come from the same clock

`timescale 1ns/10ps

module bta_term (
  // term configuration and result
  bta_term_if.term t
);
  logic eq;
  logic inr;

  // masked compare, care bit high means compare
  assign eq = ((t.word ^ t.value) & t.care) == 32'h0000_0000;
  // whole-word range from previous term value to this one
  assign inr = (t.word >= t.lo) && (t.word <= t.value);
  assign t.hit = t.en & (t.neg ^ (t.rng ? inr : eq));
endmodule : bta_term

// *** verilog/bta_timetag.sv ***
// bus trace trigger capture: time-tag clock selection and counter
// assumes the external clip is asynchronous to pclk

`timescale 1ns/10ps

module bta_timetag
  import bta_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // external tag clock pin
  input wire logic timetag_external_clock_clip,
  // control and count
  bta_tag_if.gen tg
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [TAG_ACC_W-1:0] acc;
    logic [TAG_W-1:0] cnt;
  } bta_tag_s;

  bta_tag_s tag_reg;
  bta_tag_s tag_next;
  logic [15:0] req;
  logic [31:0] prod;
  logic [23:0] prog_inc;
  logic [39:0] hz_full;
  logic [23:0] inc;
  logic [24:0] sum;
  logic tick;

  //////////////////////////////////////////////////////////////////////////////
  // programmable rate, clamped and rounded to nearest step
  always_comb begin
    if (tg.prog_req < 16'(PROG_MIN_HZ)) begin
      req = 16'(PROG_MIN_HZ);
    end else if (tg.prog_req > 16'(PROG_MAX_HZ)) begin
      req = 16'(PROG_MAX_HZ);
    end else begin
      req = tg.prog_req;
    end
    prod = 32'(req) * PROG_MUL;
    prog_inc = 24'((prod + 32'h0000_8000) >> PROG_SH);
    hz_full = (40'(prog_inc) * 40'(CLK_HZ)) >> TAG_ACC_W;
  end

  assign tg.prog_hz = hz_full[15:0];

  //////////////////////////////////////////////////////////////////////////////
  // source select
  always_comb begin
    case (tg.src)
      src_16m: inc = INC_16M;
      src_8m: inc = INC_8M;
      src_4m: inc = INC_4M;
      src_2m: inc = INC_2M;
      src_1m: inc = INC_1M;
      src_prog: inc = prog_inc;
      default: inc = 24'h00_0000;
    endcase
    sum = {1'b0, tag_reg.acc} + {1'b0, inc};
    case (tg.src)
      src_ext: tick = tag_reg.s2 & ~tag_reg.s3;
      src_emu: tick = tg.bus_stb;
      default: tick = sum[24];
    endcase
  end

  always_comb begin
    tag_next = tag_reg;
    tag_next.s1 = timetag_external_clock_clip;
    tag_next.s2 = tag_reg.s1;
    tag_next.s3 = tag_reg.s2;
    tag_next.acc = sum[23:0];
    if (tg.clr) begin
      tag_next.acc = '0;
      tag_next.cnt = '0;
    end else if (tick) begin
      tag_next.cnt = tag_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_reg <= '0;
    end else begin
      tag_reg <= tag_next;
    end
  end

  assign tg.count = tag_reg.cnt;
endmodule : bta_timetag

// *** verilog/bta_capture.sv ***
// bus trace trigger capture: apb registers, event terms, trigger sequencer
// assumes bus cycle inputs and breakpoint come from logic on pclk
//
// Added by the designer: the APB register port and the register addresses.

`timescale 1ns/10ps

// Overview of operation
// - continuous all-cycles: store all cycles to breakpoint, disarm or stop
// - continuous events-only: store matches to breakpoint, disarm or stop
// - counted all-cycles: store cycles until count reached, or earlier end
// - counted events-only: store matching cycles until count or earlier end
// - any-event: store all, trigger on any term, then post count
// - two-stage: A or B, then C or D triggers, then post count
// - three-step: A, B, C in order; D restarts at A
// - four-step: A, B, C, D in order trigger, then post count
// - nth event: count matches to N, then capture next 4096 cycles
// - count setting used only in counted, any-event and sequential modes
// - stop-emulator option halts execution when recording completes
// - every stored frame carries the low 16 time-tag counter bits
// - tag source: 16/8/4/2/1 MHz, clip, programmable, bus; default 16
// - programmable tag rate 50 Hz to 50 kHz, achieved rate readable
// - bus clock source counts one per bus cycle
// - mux picks clip data or high tag bits per frame; clips default
// - terms are 32-bit compare words; range spans two whole words
// - per-bit don't-care and optional negation of each term
// - disarm ends collection only; stop also halts emulation
module bta_capture
  import bta_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // observed bus
  input wire logic bus_cycle_stb,
  input wire logic [31:0] bus_cycle_word,
  input wire logic [7:0] probe_b_clips,
  input wire logic breakpoint_hit,
  input wire logic timetag_external_clock_clip,
  // trace buffer write port
  output logic trace_wr,
  output logic [31:0] trace_word,
  output logic [15:0] trace_tag,
  output logic [7:0] trace_aux,
  output logic trace_trig,
  // emulation control
  output logic emulation_halt
);
  if (CNT_W < 13 || CNT_W > 32) begin : g_chk
    $error("CNT_W must hold the nth post count and fit a word");
  end

  typedef struct packed {
    bta_state_e state;
    bta_mode_e mode;
    logic stop_emu;
    logic trace_mux_select;
    bta_src_e src;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] nth;
    logic [15:0] prog_req;
    logic [15:0] term_ctrl;
    logic [3:0][31:0] value;
    logic [3:0][31:0] care;
    logic [1:0] stage;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] ncnt;
    logic halt;
    logic tag_clr;
    logic [31:0] prdata;
    logic pslverr;
    logic trace_wr;
    logic [31:0] trace_word;
    logic [15:0] trace_tag;
    logic [7:0] trace_aux;
    logic trace_trig;
  } bta_cap_s;

  bta_cap_s cap_reg;
  bta_cap_s cap_next;
  bta_term_if term_if [4] ();
  bta_tag_if tag_if ();
  logic [3:0] hit;
  logic any_hit;
  logic wr_acc;
  logic addr_ok;
  logic [31:0] rd_val;
  logic [1:0] ti;
  logic arm_w;
  logic disarm_w;
  logic stop_w;
  logic store;
  logic trig;
  logic collecting;
  logic [CNT_W-1:0] lim;
  logic [CNT_W-1:0] cnt_inc;

  //////////////////////////////////////////////////////////////////////////////
  // event terms
  for (genvar g = 0; g < 4; g++) begin : g_term
    assign term_if[g].word = bus_cycle_word;
    assign term_if[g].value = cap_reg.value[g];
    assign term_if[g].care = cap_reg.care[g];
    assign term_if[g].lo = cap_reg.value[(g + 3) % 4];
    assign term_if[g].en = cap_reg.term_ctrl[4*g+TC_EN];
    assign term_if[g].neg = cap_reg.term_ctrl[4*g+TC_NEG];
    assign term_if[g].rng = (g != 0) && cap_reg.term_ctrl[4*g+TC_RNG];
    assign hit[g] = term_if[g].hit;
    bta_term u_term (
      .t(term_if[g])
    );
  end
  assign any_hit = |hit;

  //////////////////////////////////////////////////////////////////////////////
  // time tag
  assign tag_if.src = cap_reg.src;
  assign tag_if.prog_req = cap_reg.prog_req;
  assign tag_if.bus_stb = bus_cycle_stb;
  assign tag_if.clr = cap_reg.tag_clr;

  bta_timetag u_timetag (
    .pclk(pclk),
    .presetn(presetn),
    .timetag_external_clock_clip(timetag_external_clock_clip),
    .tg(tag_if)
  );

  //////////////////////////////////////////////////////////////////////////////
  // address decode and read mux
  always_comb begin
    ti = paddr[4:3];
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end else if (paddr == OFF_CTRL) begin
      rd_val[CTRL_MODE_LSB+:4] = cap_reg.mode;
      rd_val[CTRL_STOPEMU_BIT] = cap_reg.stop_emu;
      rd_val[CTRL_MUX_BIT] = cap_reg.trace_mux_select;
      rd_val[CTRL_SRC_LSB+:3] = cap_reg.src;
    end else if (paddr == OFF_STATUS) begin
      rd_val[1:0] = cap_reg.state;
      rd_val[3:2] = cap_reg.stage;
      rd_val[4] = cap_reg.halt;
    end else if (paddr == OFF_COUNT) begin
      rd_val[CNT_W-1:0] = cap_reg.count;
    end else if (paddr == OFF_NTH) begin
      rd_val[CNT_W-1:0] = cap_reg.nth;
    end else if (paddr == OFF_PROG_REQ) begin
      rd_val[15:0] = cap_reg.prog_req;
    end else if (paddr == OFF_PROG_HZ) begin
      rd_val[15:0] = tag_if.prog_hz;
    end else if (paddr == OFF_TERM_CTRL) begin
      rd_val[15:0] = cap_reg.term_ctrl;
    end else if (paddr >= OFF_TERM_BASE && paddr <= OFF_TERM_END) begin
      rd_val = paddr[2] ? cap_reg.care[ti] : cap_reg.value[ti];
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign arm_w = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_ARM_BIT];
  assign disarm_w = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_DISARM_BIT];
  assign stop_w = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_STOP_BIT];
  assign collecting = cap_reg.state == st_pre || cap_reg.state == st_post;
  assign lim = (cap_reg.mode == mode_nth) ? CNT_W'(NTH_POST_CYCLES)
                                           : cap_reg.count;
  assign cnt_inc = cap_reg.cnt + 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // store and trigger decision for one bus cycle
  always_comb begin
    store = 1'b0;
    trig = 1'b0;
    if (cap_reg.state == st_post) begin
      store = 1'b1;
    end else begin
      case (cap_reg.mode)
        mode_cont_all: store = 1'b1;
        mode_cnt_all: store = 1'b1;
        mode_cont_evt: store = any_hit;
        mode_cnt_evt: store = any_hit;
        mode_any: begin
          store = 1'b1;
          trig = any_hit;
        end
        mode_ab_cd: begin
          store = 1'b1;
          trig = cap_reg.stage == 2'd1 && (hit[2] | hit[3]);
        end
        mode_abc_nd: begin
          store = 1'b1;
          trig = !hit[3] && cap_reg.stage == 2'd2 && hit[2];
        end
        mode_abcd: begin
          store = 1'b1;
          trig = cap_reg.stage == 2'd3 && hit[3];
        end
        mode_nth: trig = any_hit && cap_reg.ncnt + 1'b1 >= cap_reg.nth;
        default: store = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    cap_next = cap_reg;
    cap_next.trace_wr = 1'b0;
    cap_next.trace_trig = 1'b0;
    cap_next.tag_clr = 1'b0;
    if (psel && !penable) begin
      cap_next.prdata = rd_val;
      cap_next.pslverr = !addr_ok;
    end
    if (wr_acc) begin
      if (paddr == OFF_CTRL) begin
        cap_next.mode = bta_mode_e'(pwdata[CTRL_MODE_LSB+:4]);
        cap_next.stop_emu = pwdata[CTRL_STOPEMU_BIT];
        cap_next.trace_mux_select = pwdata[CTRL_MUX_BIT];
        cap_next.src = bta_src_e'(pwdata[CTRL_SRC_LSB+:3]);
      end else if (paddr == OFF_COUNT) begin
        cap_next.count = pwdata[CNT_W-1:0];
      end else if (paddr == OFF_NTH) begin
        cap_next.nth = pwdata[CNT_W-1:0];
      end else if (paddr == OFF_PROG_REQ) begin
        cap_next.prog_req = pwdata[15:0];
      end else if (paddr == OFF_TERM_CTRL) begin
        cap_next.term_ctrl = pwdata[15:0];
      end else if (paddr >= OFF_TERM_BASE) begin
        if (paddr[2]) begin
          cap_next.care[ti] = pwdata;
        end else begin
          cap_next.value[ti] = pwdata;
        end
      end
    end
    if (arm_w) begin
      cap_next.state = st_pre;
      cap_next.stage = 2'd0;
      cap_next.cnt = '0;
      cap_next.ncnt = '0;
      cap_next.halt = 1'b0;
      cap_next.tag_clr = 1'b1;
    end else if (disarm_w) begin
      cap_next.state = st_idle;
    end else if (stop_w) begin
      cap_next.state = st_done;
      cap_next.halt = 1'b1;
    end else if (collecting && breakpoint_hit) begin
      cap_next.state = st_done;
    end else if (collecting && bus_cycle_stb) begin
      if (cap_reg.state == st_pre) begin
        if (cap_reg.mode == mode_ab_cd && cap_reg.stage == 2'd0) begin
          if (hit[0] | hit[1]) cap_next.stage = 2'd1;
        end else if (cap_reg.mode == mode_abc_nd) begin
          if (hit[3]) begin
            cap_next.stage = 2'd0;
          end else if (hit[cap_reg.stage] && cap_reg.stage != 2'd2) begin
            cap_next.stage = cap_reg.stage + 1'b1;
          end
        end else if (cap_reg.mode == mode_abcd) begin
          if (hit[cap_reg.stage] && cap_reg.stage != 2'd3) begin
            cap_next.stage = cap_reg.stage + 1'b1;
          end
        end else if (cap_reg.mode == mode_nth && any_hit) begin
          cap_next.ncnt = cap_reg.ncnt + 1'b1;
        end
      end
      if (store) begin
        cap_next.trace_wr = 1'b1;
        cap_next.trace_word = bus_cycle_word;
        cap_next.trace_tag = tag_if.count[TAG_LO_W-1:0];
        cap_next.trace_aux = cap_reg.trace_mux_select
                             ? tag_if.count[TAG_W-1:TAG_LO_W]
                             : probe_b_clips;
        cap_next.trace_trig = trig;
        cap_next.cnt = cnt_inc;
      end
      if (trig) begin
        cap_next.state = st_post;
        cap_next.cnt = '0;
        if (lim == '0) begin
          cap_next.state = st_done;
          cap_next.halt = cap_reg.halt | cap_reg.stop_emu;
        end
      end else if (store && cnt_inc >= lim &&
                   (cap_reg.state == st_post ||
                    cap_reg.mode == mode_cnt_all ||
                    cap_reg.mode == mode_cnt_evt)) begin
        cap_next.state = st_done;
        cap_next.halt = cap_reg.halt | cap_reg.stop_emu;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_reg <= '0;
      cap_reg.state <= st_idle;
      cap_reg.mode <= mode_cont_all;
      cap_reg.src <= src_16m;
      cap_reg.count <= CNT_W'(COUNT_RST);
      cap_reg.nth <= CNT_W'(NTH_RST);
      cap_reg.prog_req <= PROG_REQ_RST;
    end else begin
      cap_reg <= cap_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign pready = 1'b1;
  assign prdata = cap_reg.prdata;
  assign pslverr = cap_reg.pslverr;
  assign trace_wr = cap_reg.trace_wr;
  assign trace_word = cap_reg.trace_word;
  assign trace_tag = cap_reg.trace_tag;
  assign trace_aux = cap_reg.trace_aux;
  assign trace_trig = cap_reg.trace_trig;
  assign emulation_halt = cap_reg.halt;
endmodule : bta_capture

// *** tb/bta_capture_checker.sv ***
// checker: port assertions for the trace capture block
// assumes bound to bta_capture, one pclk domain
`timescale 1ns/10ps
module bta_capture_checker
  import bta_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // observed bus
  input wire logic bus_cycle_stb,
  input wire logic [31:0] bus_cycle_word,
  input wire logic breakpoint_hit,
  // trace and halt
  input wire logic trace_wr,
  input wire logic [31:0] trace_word,
  input wire logic trace_trig,
  input wire logic emulation_halt
);
  logic cw, arm, dis, stp;
  assign cw = psel && penable && pwrite && paddr == OFF_CTRL;
  assign arm = cw && pwdata[CTRL_ARM_BIT];
  assign dis = cw && pwdata[CTRL_DISARM_BIT];
  assign stp = cw && pwdata[CTRL_STOP_BIT];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////////
  AST_FRAME_CAUSE: assert property (trace_wr |-> $past(bus_cycle_stb))
    else $error("frame without bus cycle");
  AST_FRAME_WORD: assert property (
    trace_wr |-> trace_word == $past(bus_cycle_word))
    else $error("frame word differs from bus word");
  AST_TRIG_FRAME: assert property (trace_trig |-> trace_wr)
    else $error("trigger flag without frame");
  AST_TRIG_ONCE: assert property (trace_trig |=> !trace_trig)
    else $error("two trigger frames in a row");
  AST_BRK_WINS: assert property (
    breakpoint_hit && bus_cycle_stb && !cw |=> !trace_wr)
    else $error("frame stored on breakpoint cycle");
  AST_BRK_NO_HALT: assert property (
    breakpoint_hit && !emulation_halt && !cw |=> !emulation_halt)
    else $error("breakpoint halted emulation");
  AST_DISARM_END: assert property (dis && !arm |=> !trace_wr [*2])
    else $error("frame after disarm");
  AST_HALT_HOLD: assert property (
    emulation_halt && !arm |=> emulation_halt)
    else $error("halt dropped without arm");
  AST_STOP_HALT: assert property (
    stp && !arm && !dis |=> emulation_halt)
    else $error("stop did not halt");
  AST_ARM_CLEAR: assert property (arm |=> !emulation_halt)
    else $error("arm left halt set");
  // main scenarios
  cover property (trace_trig);
  cover property (stp && !arm && !dis);
  cover property (breakpoint_hit && bus_cycle_stb);
endmodule : bta_capture_checker

// *** tb/bta_bus_model.sv ***
// partner: emulated processor bus producing observed cycles
// assumes cycle strobes synchronous to clk
`timescale 1ns/10ps
module bta_bus_model (
  // clock
  input wire logic clk,
  // observed bus
  output logic stb,
  output logic [31:0] word,
  output logic [7:0] clips,
  output logic brk,
  output logic ext_clk
);
  initial begin
    stb = 1'b0;
    word = 32'h0;
    clips = 8'h0;
    brk = 1'b0;
    ext_clk = 1'b0;
  end
  // back-to-back cycles, then bus released with inverted lines
  task automatic run(input logic [31:0] ws[$]);
    foreach (ws[i]) begin
      @(posedge clk);
      stb <= 1'b1;
      word <= ws[i];
      clips <= ws[i][31:24];
    end
    @(posedge clk);
    stb <= 1'b0;
    word <= ~word;
    clips <= ~clips;
  endtask : run
  // breakpoint together with a bus cycle
  task automatic hit(input logic [31:0] w);
    @(posedge clk);
    brk <= 1'b1;
    stb <= 1'b1;
    word <= w;
    @(posedge clk);
    brk <= 1'b0;
    stb <= 1'b0;
    word <= ~word;
  endtask : hit
endmodule : bta_bus_model

// *** tb/bta_capture_test.sv ***
// testbench: apb-driven scenarios for the trace capture block
// assumes package, carriers and design modules compiled first
`timescale 1ns/10ps
module bta_capture_test;
  import bta_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, clips, trace_aux;
  logic [31:0] pwdata, prdata, word, trace_word, rd;
  logic stb, brk, ext, trace_wr, trace_trig, halt, err;
  logic [15:0] trace_tag;
  int n_fail, tests_run;
  logic [31:0] fw[$];
  logic ft[$];
  logic [15:0] fg[$];
  logic [7:0] fa[$];
  localparam logic [31:0] ARM = 32'h1 << CTRL_ARM_BIT;
  bta_capture #(.CNT_W(16)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_cycle_stb(stb), .bus_cycle_word(word), .probe_b_clips(clips),
    .breakpoint_hit(brk), .timetag_external_clock_clip(ext),
    .trace_wr(trace_wr), .trace_word(trace_word), .trace_tag(trace_tag),
    .trace_aux(trace_aux), .trace_trig(trace_trig), .emulation_halt(halt));
  bta_bus_model u_bus (.clk(pclk), .stb(stb), .word(word), .clips(clips),
    .brk(brk), .ext_clk(ext));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // frame collector
  always @(posedge pclk) begin
    if (trace_wr === 1'b1) begin
      fw.push_back(trace_word);
      ft.push_back(trace_trig);
      fg.push_back(trace_tag);
      fa.push_back(trace_aux);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task automatic arm_in(input logic [31:0] v);
    fw.delete();
    ft.delete();
    fg.delete();
    fa.delete();
    apb(1'b1, OFF_CTRL, v | ARM);
  endtask : arm_in
  task automatic terms(input logic [31:0] tc);
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, OFF_TERM_BASE + 8'(8 * n), 32'ha0 + 32'(16 * n));
      apb(1'b1, OFF_TERM_BASE + 8'(8 * n + 4), 32'hffffffff);
    end
    apb(1'b1, OFF_TERM_CTRL, tc);
  endtask : terms
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] ad[5] = '{OFF_CTRL, OFF_STATUS, OFF_COUNT, OFF_NTH,
      OFF_PROG_HZ};
    logic [31:0] ex[5] = '{32'h0, 32'h0, 32'h100, 32'h1, 32'h3e8};
    foreach (ad[i]) begin
      apb(1'b0, ad[i], 32'h0);
      chk("reset value", ex[i], rd);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    apb(1'b1, OFF_PROG_REQ, 32'd10);
    apb(1'b0, OFF_PROG_HZ, 32'h0);
    chk("prog clamp", 32'd50, rd);
  endtask : t_reset
  task automatic t_cont;
    logic [31:0] ws[$] = '{32'h11000001, 32'h22000002, 32'h33000003};
    arm_in(32'h0);
    u_bus.run(ws);
    u_bus.hit(32'h99);
    u_bus.run('{4, 5});
    settle();
    chk("cont frames", 32'd3, 32'(fw.size()));
    foreach (fw[i]) begin
      chk("cont word", ws[i], fw[i]);
      chk("clip aux", 32'(ws[i][31:24]), 32'(fa[i]));
    end
    chk("brk halt", 32'h0, 32'(halt));
  endtask : t_cont
  task automatic t_evt;
    for (int neg = 0; neg < 2; neg++) begin
      terms(32'h1 | 32'(neg << 1));
      arm_in(32'(mode_cont_evt));
      u_bus.run('{32'ha0, 32'h5, 32'ha0});
      settle();
      chk("evt frames", neg ? 32'd1 : 32'd2, 32'(fw.size()));
      chk("evt word", neg ? 32'h5 : 32'ha0, fw[0]);
      apb(1'b1, OFF_CTRL, 32'h1 << CTRL_STOP_BIT);
      settle();
      chk("stop halt", 32'h1, 32'(halt));
    end
  endtask : t_evt
  task automatic t_count;
    apb(1'b1, OFF_COUNT, 32'd3);
    arm_in(32'(mode_cnt_all) | 32'h10);
    u_bus.run('{1, 2, 3, 4, 5});
    settle();
    chk("cnt frames", 32'd3, 32'(fw.size()));
    chk("done halt", 32'h1, 32'(halt));
    apb(1'b1, OFF_CTRL, 32'h1 << CTRL_DISARM_BIT);
    settle();
    chk("disarm keeps halt", 32'h1, 32'(halt));
    terms(32'h1);
    arm_in(32'(mode_cnt_evt));
    settle();
    chk("arm clears halt", 32'h0, 32'(halt));
    u_bus.run('{32'ha0, 32'h1, 32'ha0, 32'ha0, 32'ha0});
    settle();
    chk("cnt evt frames", 32'd3, 32'(fw.size()));
  endtask : t_count
  task automatic t_seq;
    bta_mode_e md[4] = '{mode_any, mode_ab_cd, mode_abc_nd, mode_abcd};
    int tix[4] = '{1, 3, 3, 4};
    logic [31:0] sq[$] = '{1, 32'ha0, 32'hb0, 32'hc0, 32'hd0, 5, 6, 7, 8};
    terms(32'h1111);
    apb(1'b1, OFF_COUNT, 32'd2);
    foreach (md[m]) begin
      arm_in(32'(md[m]));
      u_bus.run(sq);
      settle();
      chk("seq frames", 32'(tix[m] + 3), 32'(fw.size()));
      chk("trig word", sq[tix[m]], fw[tix[m]]);
      chk("trig flag", 32'h1, 32'(ft[tix[m]]));
    end
  endtask : t_seq
  task automatic t_nth;
    logic [31:0] q[$] = '{32'ha0, 32'h1, 32'ha0};
    for (int i = 0; i < NTH_POST_CYCLES + 1; i++) q.push_back(32'h1000 + i);
    terms(32'h1);
    apb(1'b1, OFF_NTH, 32'd2);
    arm_in(32'(mode_nth));
    u_bus.run(q);
    settle();
    chk("nth frames", 32'(NTH_POST_CYCLES), 32'(fw.size()));
    chk("nth first", 32'h1000, fw[0]);
  endtask : t_nth
  task automatic t_tag;
    arm_in(32'(src_emu) << CTRL_SRC_LSB | 32'h1 << CTRL_MUX_BIT);
    u_bus.run('{1, 2, 3});
    u_bus.run('{4});
    settle();
    for (int i = 1; i < 4; i++) begin
      chk("tag step", 32'h1, 32'(fg[i] - fg[i - 1]));
      chk("tag high aux", 32'h0, 32'(fa[i]));
    end
  endtask : t_tag
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cont();
    t_evt();
    t_count();
    t_seq();
    t_nth();
    t_tag();
    end_sim();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    end_sim();
  end
endmodule : bta_capture_test
bind bta_capture bta_capture_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .bus_cycle_stb(bus_cycle_stb),
  .bus_cycle_word(bus_cycle_word), .breakpoint_hit(breakpoint_hit),
  .trace_wr(trace_wr), .trace_word(trace_word), .trace_trig(trace_trig),
  .emulation_halt(emulation_halt));
